// file: src/scr_strap_regs.sv
/*
  Strap capture register bank: samples board straps after reset, holds them,
  and serves them read-only through an index/data I/O port pair.
  Strap images live in flip-flops; the decoded multiplier, boot width and
  synthesizer setting are combinational views of those images.
  Assumes single-cycle io_rd/io_wr strobes on core_clk and static strap pins.
  Assumes the straps stay put from reset release until the third clock edge,
  when the image is loaded.
*/
// Contract
// - Bits 7-6 decode as X1 for lo-strap high with hi-strap low, X2 for both high, else reserved.
// - Bit 0 of the multiplier register reports boot width, 0 for 8-bit and 1 for 16-bit.
// - Each strap bit takes the level sampled on its pin after reset.
// - The host-clock strap register ignores all software writes.
// - Bits 7-6 of the host-clock strap register always read zero.
// - Bits 5-3 of the host-clock strap register show the three synth-select straps and drive the synthesizer.
// - With both speed straps low, selects 000/001/010/011 give 25/50/60/66 MHz, all else reserved.
// - The host-clock strap register is reached via ports 0022h/0023h at index 05Fh.
// - The multiplier and boot width register is read-only.
module scr_strap_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire scr_pkg::scr_straps_s straps_pin,
  input  wire logic [15:0]          io_addr,
  input  wire logic                 io_rd,
  input  wire logic                 io_wr,
  input  wire logic [7:0]           io_wdata,
  output logic      [7:0]           io_rdata,
  output logic                      io_rdata_valid,
  output logic                      straps_ready,
  output scr_pkg::scr_mult_e        cpu_mult,
  output logic                      boot_width_16,
  output logic      [2:0]           synth_select,
  output scr_pkg::scr_freq_e        synth_freq
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic scr_pkg::scr_mult_e decode_mult(input logic hi, input logic lo);
    scr_pkg::scr_mult_e m;
    m = scr_pkg::SCR_MULT_RESERVED;
    if (lo && !hi) begin
      m = scr_pkg::SCR_MULT_X1;
    end else if (lo && hi) begin
      m = scr_pkg::SCR_MULT_X2;
    end
    return m;
  endfunction

  function automatic scr_pkg::scr_freq_e decode_freq(input logic [4:0] sel);
    scr_pkg::scr_freq_e f;
    f = scr_pkg::SCR_FREQ_RESERVED;
    case (sel)
      5'h00:   f = scr_pkg::SCR_FREQ_25;
      5'h01:   f = scr_pkg::SCR_FREQ_50;
      5'h02:   f = scr_pkg::SCR_FREQ_60;
      5'h03:   f = scr_pkg::SCR_FREQ_66;
      default: f = scr_pkg::SCR_FREQ_RESERVED;
    endcase
    return f;
  endfunction

  // Address and index matches, shared by decode and the write path
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    return addr == port;
  endfunction

  function automatic logic index_is(input logic [7:0] idx, input logic [7:0] which);
    return idx == which;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser and one-shot capture
  // ----------------------------------------------------------------
  scr_pkg::scr_straps_s sync_meta;
  scr_pkg::scr_straps_s sync_pins;
  scr_pkg::scr_straps_s captured;
  logic [1:0]           cap_cnt;
  logic                 cap_now;

  // Second stage is the only reader of the first
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= '0;
      sync_pins <= '0;
    end else begin
      sync_meta <= straps_pin;
      sync_pins <= sync_meta;
    end
  end

  // ----------------------------------------------------------------
  // Capture sequencing
  // ----------------------------------------------------------------
  // Wait until the synchroniser holds post-release samples
  assign cap_now = !straps_ready && (cap_cnt == scr_pkg::SCR_CAPTURE_WAIT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt <= '0;
    end else if (!straps_ready && cap_now == 1'b0) begin
      cap_cnt <= cap_cnt + 2'h1;
    end
  end

  // Loaded once, then frozen until the next reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      captured <= '0;
    end else if (cap_now) begin
      captured <= sync_pins;
    end
  end

  // Sticky until reset, so a late pin change can never reload the image
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      straps_ready <= 1'b0;
    end else if (cap_now) begin
      straps_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  logic [7:0] mult_boot_width_straps;
  logic [7:0] host_clock_select_straps;

  // Reserved positions keep the reset byte
  always_comb begin
    mult_boot_width_straps = scr_pkg::SCR_RESET_BYTE;
    mult_boot_width_straps[scr_pkg::SCR_MULT_HI_BIT] = captured.mult_strap_hi;
    mult_boot_width_straps[scr_pkg::SCR_MULT_LO_BIT] = captured.mult_strap_lo;
    mult_boot_width_straps[scr_pkg::SCR_BOOT_W_BIT]  = captured.boot_width_strap;
  end

  always_comb begin
    host_clock_select_straps = scr_pkg::SCR_RESET_BYTE;
    host_clock_select_straps[scr_pkg::SCR_SYNTH_LSB +: 3] = captured.synth_select_straps;
  end

  // ----------------------------------------------------------------
  // Decoded configuration outputs
  // ----------------------------------------------------------------
  logic [4:0] freq_sel;

  // Speed straps sit above the select straps, as the lookup expects
  assign freq_sel      = {captured.speed_strap_b, captured.speed_strap_a, captured.synth_select_straps};
  assign cpu_mult      = decode_mult(captured.mult_strap_hi, captured.mult_strap_lo);
  assign boot_width_16 = captured.boot_width_strap;
  assign synth_select  = captured.synth_select_straps;
  assign synth_freq    = decode_freq(freq_sel);

  // ----------------------------------------------------------------
  // Index/data I/O port pair
  // ----------------------------------------------------------------
  logic [7:0] reg_index;
  logic       hit_index;
  logic       hit_data;
  logic       idx_hclk;
  logic       idx_mult;
  logic       wr_index;
  logic [7:0] data_sel;
  logic [7:0] next_rdata;

  assign hit_index = port_hit(io_addr, scr_pkg::SCR_INDEX_PORT);
  assign hit_data  = port_hit(io_addr, scr_pkg::SCR_DATA_PORT);
  assign idx_hclk  = index_is(reg_index, scr_pkg::SCR_IDX_HCLK);
  assign idx_mult  = index_is(reg_index, scr_pkg::SCR_IDX_MULT);
  assign wr_index  = io_wr && hit_index;

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  // Unknown indexes read zero; data port writes are dropped
  assign data_sel =
      idx_hclk ? host_clock_select_straps :
      idx_mult ? mult_boot_width_straps :
      scr_pkg::SCR_RESET_BYTE;

  assign next_rdata = hit_index ? reg_index : (hit_data ? data_sel : scr_pkg::SCR_RESET_BYTE);

  // ----------------------------------------------------------------
  // Index latch
  // ----------------------------------------------------------------
  // Only the index latch is writable; strap images have no write path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_index <= scr_pkg::SCR_RESET_INDEX;
    end else if (wr_index) begin
      reg_index <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read response
  // ----------------------------------------------------------------
  // Valid follows every read, mapped or not, so software never stalls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_valid <= 1'b0;
    end else begin
      io_rdata_valid <= io_rd;
    end
  end

  // Data holds between reads; nothing needs to clear it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= scr_pkg::SCR_RESET_BYTE;
    end else if (io_rd) begin
      io_rdata <= next_rdata;
    end
  end

endmodule // scr_strap_regs

// file: pkg/scr_pkg.sv
/*
  Constants, types and field layout for the strap capture register bank.
  Assumes an 8-bit indexed I/O port pair and straps sampled once after reset.
*/
package scr_pkg;

  // ----------------------------------------------------------------
  // I/O ports and register indexes
  // ----------------------------------------------------------------
  localparam logic [15:0] SCR_INDEX_PORT = 16'h0022;
  localparam logic [15:0] SCR_DATA_PORT  = 16'h0023;
  localparam logic [7:0]  SCR_IDX_MULT   = 8'h4B;
  localparam logic [7:0]  SCR_IDX_HCLK   = 8'h5F;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          SCR_MULT_HI_BIT   = 7;
  localparam int          SCR_MULT_LO_BIT   = 6;
  localparam int          SCR_BOOT_W_BIT    = 0;
  localparam int          SCR_SYNTH_LSB     = 3;
  localparam logic [7:0]  SCR_RESET_BYTE    = 8'h00;
  localparam logic [7:0]  SCR_RESET_INDEX   = 8'h00;
  localparam logic [1:0]  SCR_CAPTURE_WAIT  = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       mult_strap_hi;
    logic       mult_strap_lo;
    logic       boot_width_strap;
    logic [2:0] synth_select_straps;
    logic       speed_strap_b;
    logic       speed_strap_a;
  } scr_straps_s;

  typedef enum logic [1:0] {
    SCR_MULT_X1,
    SCR_MULT_X2,
    SCR_MULT_RESERVED
  } scr_mult_e;

  typedef enum logic [2:0] {
    SCR_FREQ_25,
    SCR_FREQ_50,
    SCR_FREQ_60,
    SCR_FREQ_66,
    SCR_FREQ_RESERVED
  } scr_freq_e;

endpackage : scr_pkg

// file: bench/scr_monitor.sv
/* Port checker for the strap register bank.
   Assumes it is bound onto scr_strap_regs. */
module scr_monitor (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic [15:0]        io_addr,
  input wire logic               io_rd,
  input wire logic               io_wr,
  input wire logic [7:0]         io_wdata,
  input wire logic [7:0]         io_rdata,
  input wire logic               io_rdata_valid,
  input wire logic               straps_ready,
  input wire scr_pkg::scr_mult_e cpu_mult,
  input wire logic               boot_width_16,
  input wire logic [2:0]         synth_select,
  input wire scr_pkg::scr_freq_e synth_freq
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Index shadow
  // ----------------------------------------------------------------
  logic [7:0] idx;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= scr_pkg::SCR_RESET_INDEX;
    end else if (io_wr && io_addr == scr_pkg::SCR_INDEX_PORT) begin
      idx <= io_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_data_rd(logic [7:0] which);
    io_rd && io_addr == scr_pkg::SCR_DATA_PORT && idx == which;
  endsequence

  // Two synchroniser edges and one load edge before the image is ready
  sequence s_capture;
    !straps_ready [*3] ##1 straps_ready;
  endsequence

  AST_RD_VALID: assert property (io_rd |=> io_rdata_valid) else $error("read unanswered");
  AST_RD_QUIET: assert property (!io_rd |=> !io_rdata_valid) else $error("stray valid");
  AST_HCLK_BITS: assert property (s_data_rd(scr_pkg::SCR_IDX_HCLK) |=>
    io_rdata == {2'h0, synth_select, 3'h0}) else $error("host clock byte wrong");
  AST_MULT_BITS: assert property (s_data_rd(scr_pkg::SCR_IDX_MULT) |=>
    io_rdata[5:0] == {5'h00, boot_width_16}) else $error("boot width byte wrong");
  AST_MULT_DEC: assert property (s_data_rd(scr_pkg::SCR_IDX_MULT) |=>
    (cpu_mult == scr_pkg::SCR_MULT_X2) == (io_rdata[7:6] == 2'h3) &&
    (cpu_mult == scr_pkg::SCR_MULT_X1) == (io_rdata[7:6] == 2'h1)) else $error("multiplier decode");
  AST_INDEX_RD: assert property (io_rd && io_addr == scr_pkg::SCR_INDEX_PORT |=>
    io_rdata == $past(idx)) else $error("index readback");
  AST_UNMAPPED: assert property (io_rd && io_addr != scr_pkg::SCR_INDEX_PORT &&
    io_addr != scr_pkg::SCR_DATA_PORT |=> io_rdata == 8'h00) else $error("unmapped read");
  AST_HOLD: assert property (straps_ready |=> straps_ready && $stable(boot_width_16) &&
    $stable(synth_select) && $stable(cpu_mult)) else $error("straps moved");
  AST_FREQ: assert property (synth_freq != scr_pkg::SCR_FREQ_RESERVED |->
    3'(synth_freq) == synth_select) else $error("frequency decode");
  AST_CAPTURE: assert property ($rose(rst_n) |-> s_capture)
    else $error("capture timing");
endmodule // scr_monitor
bind scr_strap_regs scr_monitor u_mon (.core_clk, .rst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
  .io_rdata_valid, .straps_ready, .cpu_mult, .boot_width_16, .synth_select, .synth_freq);

// file: bench/scr_strap_model.sv
/* Board strap resistors.
   Assumes the bench picks the strapping per reset. */
module scr_strap_model (
  input  wire logic [7:0]      strap_cfg,
  output scr_pkg::scr_straps_s straps_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pulls follow strap_cfg, host clock kept at or below 66 MHz by the table
  assign straps_pin = scr_pkg::scr_straps_s'(strap_cfg);
endmodule // scr_strap_model

// file: bench/strap_capture_registers_bench.sv
/* Bench: strap tables through reset, read back over the index/data ports.
   Assumes the strap model and the bound checker. */
module strap_capture_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst_n = 0, io_rd = 0, io_wr = 0, io_rdata_valid, straps_ready, boot_width_16;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, cfg = 8'h00, io_rdata, xm, xh;
  logic [2:0] synth_select;
  scr_pkg::scr_straps_s straps_pin;
  scr_pkg::scr_mult_e cpu_mult, xmul;
  scr_pkg::scr_freq_e synth_freq, xf;
  int errors = 0, checks_done = 0;
  logic [7:0] cfgs [6] = '{8'h40, 8'hE4, 8'h88, 8'h2C, 8'hD1, 8'h4E};
  initial forever #5 core_clk = ~core_clk;
  scr_strap_model u_pins (.strap_cfg(cfg), .straps_pin);
  scr_strap_regs dut (.core_clk, .rst_n, .straps_pin, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .io_rdata_valid, .straps_ready, .cpu_mult, .boot_width_16, .synth_select, .synth_freq);
  // ----
  // Check, port access and verdict tasks
  // ----
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    @(posedge core_clk) #1 io_wr = 0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge core_clk) #1 {io_addr, io_rd} = {a, 1'b1};
    @(posedge core_clk) #1 io_rd = 0;
    chk({7'h00, io_rdata_valid}, 8'h01);
    chk(io_rdata, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    foreach (cfgs[i]) begin
      cfg = cfgs[i];
      rst_n = 0;
      repeat (4) @(posedge core_clk);
      #1 rst_n = 1;
      xm = {cfg[7:6], 5'h00, cfg[5]};
      xh = {2'h0, cfg[4:2], 3'h0};
      xmul = !cfg[6] ? scr_pkg::SCR_MULT_RESERVED : cfg[7] ? scr_pkg::SCR_MULT_X2 : scr_pkg::SCR_MULT_X1;
      xf = (cfg[1:0] == 2'h0 && !cfg[4]) ? scr_pkg::scr_freq_e'({1'b0, cfg[3:2]}) : scr_pkg::SCR_FREQ_RESERVED;
      repeat (4) @(posedge core_clk);
      #1 chk({7'h00, straps_ready}, 8'h01);
      chk(8'(cpu_mult), 8'(xmul));
      chk(8'(synth_freq), 8'(xf));
      chk({5'h00, synth_select}, {5'h00, cfg[4:2]});
      wr(scr_pkg::SCR_INDEX_PORT, scr_pkg::SCR_IDX_MULT);
      rd(scr_pkg::SCR_DATA_PORT, xm);
      wr(scr_pkg::SCR_DATA_PORT, ~xm);
      rd(scr_pkg::SCR_DATA_PORT, xm);
      wr(scr_pkg::SCR_INDEX_PORT, 8'h60);
      rd(scr_pkg::SCR_DATA_PORT, 8'h00);
      wr(scr_pkg::SCR_INDEX_PORT, scr_pkg::SCR_IDX_HCLK);
      wr(scr_pkg::SCR_DATA_PORT, 8'hFF);
      cfg = ~cfg;
      rd(scr_pkg::SCR_DATA_PORT, xh);
      rd(scr_pkg::SCR_INDEX_PORT, scr_pkg::SCR_IDX_HCLK);
      rd(16'h0030, 8'h00);
      chk({7'h00, boot_width_16}, {7'h00, xm[0]});
      $display("test %0d done", i);
    end
    give_verdict();
  end
  initial begin
    // About 30 cycles per strap table, six tables; ample margin
    #20000;
    errors++;
    give_verdict();
  end
endmodule // strap_capture_registers_bench
